/* File: hdl/dcr_defines.svh */
// register map, field positions, reset values and timing constants
// assumes inclusion by bare name from the design files
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define DCR_A_CTRL   8'h00
`define DCR_A_WIND   8'h04
`define DCR_A_RATIO  8'h08
`define DCR_A_HARM   8'h0C
`define DCR_A_HARM4  8'h10
`define DCR_A_TIME   8'h14
`define DCR_A_CHR1   8'h18
`define DCR_A_CHR2   8'h1C
`define DCR_A_CHR3   8'h20
`define DCR_A_STAT   8'h24
// ************************************************************
// fields
// ************************************************************
`define DCR_B_H2EN   0
`define DCR_B_H4EN   1
`define DCR_B_H5EN   2
`define DCR_B_SATEN  3
`define DCR_B_XBLK   4
`define DCR_B_ACB    5
`define DCR_F_VG     3:0
`define DCR_F_W1S    6:4
`define DCR_F_W2S    10:8
`define DCR_F_LO     15:0
`define DCR_F_HI     31:16
`define DCR_F_H2T    7:0
`define DCR_F_H2S    15:8
`define DCR_F_H5T    23:16
`define DCR_F_H5S    31:24
`define DCR_F_H4     7:0
`define DCR_F_SRST   2:0
`define DCR_F_STRP   5:3
`define DCR_B_STRA   6
`define DCR_F_SLCK   9:7
// ************************************************************
// reset values, fixed point, bus and time
// ************************************************************
`define DCR_RST_ZERO  32'h0000_0000
`define DCR_RST_RATIO 32'h1000_1000
`define DCR_RATIO_ONE 16'h1000
`define DCR_THIRD     18'h05555
`define DCR_HSIZE_WORD 3'b010
`define DCR_CLK_HZ    20000000
`define DCR_TICK_MS   1
`define DCR_BLOCK_S   1
`define DCR_MS_PER_S  1000
`endif

/* File: hdl/dcr_pkg.sv */
// types shared by the compensation and restraint design files
// assumes nothing beyond the defines header
package dcr_pkg;
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } dcr_phasor_t;
  typedef dcr_phasor_t [2:0] dcr_ph3_t;
  typedef enum logic [2:0] {
    DCR_Y, DCR_D, DCR_Z, DCR_YN, DCR_ZN
  } dcr_scheme_t;
  typedef enum logic [1:0] {SAT_IDLE, SAT_HOLD, SAT_LOCK} dcr_sat_st_t;
  typedef struct packed {
    dcr_ph3_t         w1;
    dcr_ph3_t         w2;
    logic [2:0][7:0]  h2_pct;
    logic [2:0][7:0]  h4_pct;
    logic [2:0][7:0]  h5_pct;
    logic [2:0][15:0] id_mag;
    logic [2:0][15:0] is_mag;
    logic [2:0]       zc;
    logic [2:0]       id_rise;
    logic [2:0]       is_rise;
    logic             energized;
  } dcr_meas_t;
  typedef struct packed {
    dcr_ph3_t         w1;
    dcr_ph3_t         w2;
    logic [2:0][15:0] offset;
    logic [2:0]       restraint;
    logic [2:0]       trip;
  } dcr_result_t;
endpackage

/* File: hdl/dcr_comp.sv */
// amplitude, angle and zero-sequence compensation of one winding
// assumes ratios in q4.12 and a rotation index of 0..11
`timescale 1ns/1ns
`include "dcr_defines.svh"
module dcr_comp
(
  input  wire dcr_pkg::dcr_ph3_t phin,   // raw phasors
  input  wire logic [15:0]       vratio, // voltage ratio with tap
  input  wire logic [15:0]       ctratio,// ct primary ratio
  input  wire logic [3:0]        rot,    // lag in 30 degree steps
  input  wire logic              acb,    // negative phase sequence
  input  wire logic              rm_zero,// winding grounded
  output dcr_pkg::dcr_ph3_t      phout   // compensated phasors
);
  import dcr_pkg::*;
  // cosine of k*30 degrees in q1.14
  function automatic logic signed [15:0] cosq(input logic [3:0] k);
    unique case (k)
      4'h0, 4'hB, 4'h1: cosq = (k == 4'h0) ? 16'sh4000 : 16'sh376D;
      4'h2, 4'hA:       cosq = 16'sh2000;
      4'h3, 4'h9:       cosq = 16'sh0000;
      4'h4, 4'h8:       cosq = 16'shE000;
      4'h5, 4'h7:       cosq = 16'shC893;
      4'h6:             cosq = 16'shC000;
      default:          cosq = 16'sh4000;
    endcase
  endfunction
  logic [3:0]         k_c;
  logic [3:0]         k_s;
  logic signed [15:0] c_q;
  logic signed [15:0] s_q;
  dcr_ph3_t           rt;
  // acb rotates the other way, so the group setting stays abc
  assign k_c = (acb && rot != 4'h0) ? 4'(4'hC - rot) : rot;
  assign k_s = (k_c < 4'h3) ? 4'(k_c + 4'h9) : 4'(k_c - 4'h3);
  assign c_q = cosq(k_c);
  assign s_q = cosq(k_s);
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_ph
      logic signed [32:0] a1r, a1i, a2r, a2i;
      logic signed [15:0] sr, si;
      logic signed [32:0] rr, ri;
      assign a1r = phin[i].re * $signed({1'b0, vratio});
      assign a1i = phin[i].im * $signed({1'b0, vratio});
      // a part-select is unsigned: keep the sign for the second product
      assign a2r = $signed(a1r[27:12]) * $signed({1'b0, ctratio});
      assign a2i = $signed(a1i[27:12]) * $signed({1'b0, ctratio});
      // factors kept small by configuration, so no saturation
      assign sr = a2r[27:12];
      assign si = a2i[27:12];
      assign rr = 33'(sr * c_q) - 33'(si * s_q);
      assign ri = 33'(sr * s_q) + 33'(si * c_q);
      assign rt[i].re = rr[29:14];
      assign rt[i].im = ri[29:14];
    end
  endgenerate
  logic signed [17:0] sum_r, sum_i;
  logic signed [35:0] z_r, z_i;
  assign sum_r = 18'(rt[0].re) + 18'(rt[1].re) + 18'(rt[2].re);
  assign sum_i = 18'(rt[0].im) + 18'(rt[1].im) + 18'(rt[2].im);
  assign z_r = sum_r * $signed(`DCR_THIRD);
  assign z_i = sum_i * $signed(`DCR_THIRD);
  generate
    for (i = 0; i < 3; i++)
    begin : g_zero
      assign phout[i].re = rm_zero ? 16'(rt[i].re - z_r[31:16])
                                   : rt[i].re;
      assign phout[i].im = rm_zero ? 16'(rt[i].im - z_i[31:16])
                                   : rt[i].im;
    end
  endgenerate
endmodule // dcr_comp

/* File: hdl/dcr_satdet.sv */
// ct saturation restraint of one phase: start, hold, removal, lockout
// assumes zc is a one-cycle strobe qualified by a fresh phasor update
`timescale 1ns/1ns
`include "dcr_defines.svh"
module dcr_satdet
#(
  parameter int BLOCK_MS = `DCR_BLOCK_S * `DCR_MS_PER_S
)
(
  input  wire logic        hclk,      // clock
  input  wire logic        hresetn,   // async reset, active low
  input  wire logic        enable,    // saturation trigger enabled
  input  wire logic        zc,        // zero crossing evaluated
  input  wire logic        ext_fault, // is rose, id stayed low
  input  wire logic        int_fault, // both id and is rose
  input  wire logic        ms_tick,   // one pulse per ms
  input  wire logic [15:0] max_ms,    // longest restraint in ms
  output logic             active,    // restraint in effect
  output logic             locked     // new start blocked
);
  import dcr_pkg::*;
  dcr_sat_st_t state_reg;
  logic [15:0] timer_reg;
  logic        int_prev_reg;
  logic        start;
  logic        remove;
  logic        expire;
  logic        unlock;
  assign start  = state_reg == SAT_IDLE && enable && zc
                  && ext_fault && !int_fault;
  assign remove = zc && int_fault && int_prev_reg;
  assign expire = ms_tick && 17'(timer_reg) + 17'h1 >= 17'(max_ms);
  assign unlock = ms_tick && timer_reg == 16'(BLOCK_MS - 1);
  assign active = state_reg == SAT_HOLD;
  assign locked = state_reg == SAT_LOCK;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= SAT_IDLE;
    else
      unique case (state_reg)
        SAT_IDLE: if (start) state_reg <= SAT_HOLD;
        SAT_HOLD: if (expire || remove) state_reg <= SAT_LOCK;
        SAT_LOCK: if (unlock) state_reg <= SAT_IDLE;
      endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_reg <= 16'h0000;
    else if (start || (active && (expire || remove)))
      timer_reg <= 16'h0000;
    else if (ms_tick && state_reg != SAT_IDLE)
      timer_reg <= 16'(timer_reg + 16'h1);
  end
  // an internal verdict only counts when the next crossing agrees
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_prev_reg <= 1'b0;
    else if (start)
      int_prev_reg <= 1'b0;
    else if (zc && active)
      int_prev_reg <= int_fault;
  end
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_sat_start: assert property (state_reg == SAT_IDLE && enable && zc
    && ext_fault && !int_fault |=> active) else $error("no sat start");
  a_no_int_start: assert property (state_reg == SAT_IDLE && int_fault
    |=> state_reg == SAT_IDLE) else $error("start on internal fault");
  a_sat_disabled: assert property (!enable && state_reg == SAT_IDLE
    |=> state_reg == SAT_IDLE) else $error("start while disabled");
  a_two_internal: assert property (active && zc && int_fault
    && int_prev_reg |=> locked) else $error("internal not removed");
  a_max_expire: assert property (active && ms_tick
    && timer_reg + 16'h1 >= max_ms |=> locked) else $error("no expiry");
  a_lock_stays: assert property (locked && !ms_tick |=> locked
    ) else $error("lockout left early");
  c_lock: cover property (active ##1 locked);
endmodule // dcr_satdet

/* File: hdl/dcr_top.sv */
// What this block does
// - scale winding 2 by voltage ratio with tap and ct ratio; winding 1 unscaled
// - rotate winding 2 by vector group factor in 30 degree steps
// - phase sequence handled internally in the angle compensation
// - remove zero sequence per winding when its scheme is grounded
// - add constant offset to the threshold while restraint is active
// - offset size is a setting in multiples of base current
// - harmonic trigger needs its enable and percentage above threshold
// - saturation trigger needs its enable and a detected external fault
// - cross block spreads a phase restraint to all three phases
// - transient 2nd and 5th levels apply for set time after energization
// - afterwards harmonic restraint follows the steady levels only
// - each zero crossing starts or keeps restraint on external fault
// - two internal verdicts in a row remove saturation restraint
// - saturation restraint never starts on an internal fault
// - maximum time removes saturation restraint regardless of fault
// - after removal new saturation restraint blocked for one second
// - trip when id reaches three-segment characteristic plus offset
//
// top of the compensation and temporary restraint block, ahb-lite slave
// assumes one ahb master and phasor estimates on the same clock
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "dcr_defines.svh"
module dcr_top
#(
  parameter int MS_CYCLES = `DCR_CLK_HZ / `DCR_MS_PER_S * `DCR_TICK_MS,
  parameter int BLOCK_MS  = `DCR_BLOCK_S * `DCR_MS_PER_S
)
(
  input  wire logic               hclk,       // clock, 20 mhz
  input  wire logic               hresetn,    // async reset, active low
  input  wire logic               hsel,       // slave select
  input  wire logic [31:0]        haddr,      // byte address
  input  wire logic [1:0]         htrans,     // transfer type
  input  wire logic               hwrite,     // write access
  input  wire logic [2:0]         hsize,      // transfer size
  input  wire logic [31:0]        hwdata,     // write data
  input  wire logic               hready,     // bus ready
  output logic [31:0]             hrdata,     // read data
  output logic                    hreadyout,  // slave ready
  output logic                    hresp,      // always okay
  input  wire logic               meas_valid, // new phasor update
  input  wire dcr_pkg::dcr_meas_t meas,       // measured values
  output logic                    res_valid,  // result strobe
  output dcr_pkg::dcr_result_t    res         // compensated result
);
  import dcr_pkg::*;
  // ************************************************************
  // bus slave
  // ************************************************************
  logic [31:0] ctrl_reg, wind_reg, ratio_reg, harm_reg;
  logic [31:0] harm4_reg, time_reg, chr1_reg, chr2_reg, chr3_reg;
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        wr_pend_reg;
  logic [7:0]  waddr_reg;
  logic        trans_act_reg;
  logic [2:0]  sat_lock;
  logic        acc;
  dcr_result_t res_reg;
  logic        res_valid_reg;
  logic [31:0] status;
  assign acc = hsel && hready && htrans[1];
  assign status = {22'h0, sat_lock, trans_act_reg,
                   res_reg.trip, res_reg.restraint};
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      `DCR_A_CTRL:  rd_mux = ctrl_reg;
      `DCR_A_WIND:  rd_mux = wind_reg;
      `DCR_A_RATIO: rd_mux = ratio_reg;
      `DCR_A_HARM:  rd_mux = harm_reg;
      `DCR_A_HARM4: rd_mux = harm4_reg;
      `DCR_A_TIME:  rd_mux = time_reg;
      `DCR_A_CHR1:  rd_mux = chr1_reg;
      `DCR_A_CHR2:  rd_mux = chr2_reg;
      `DCR_A_CHR3:  rd_mux = chr3_reg;
      `DCR_A_STAT:  rd_mux = status;
      default:      rd_mux = `DCR_RST_ZERO;
    endcase
  endfunction
  // zero wait states: read data is fetched in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg    <= `DCR_RST_ZERO;
      hreadyout_reg <= 1'b0;
      wr_pend_reg   <= 1'b0;
      waddr_reg     <= 8'h00;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      wr_pend_reg   <= acc && hwrite && hsize == `DCR_HSIZE_WORD;
      waddr_reg     <= haddr[7:0];
      if (acc && !hwrite)
        hrdata_reg <= rd_mux(haddr[7:0]);
    end
  end
  // settings of the active parameter set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg  <= `DCR_RST_ZERO;
      wind_reg  <= `DCR_RST_ZERO;
      ratio_reg <= `DCR_RST_RATIO;
      harm_reg  <= `DCR_RST_ZERO;
      harm4_reg <= `DCR_RST_ZERO;
      time_reg  <= `DCR_RST_ZERO;
      chr1_reg  <= `DCR_RST_ZERO;
      chr2_reg  <= `DCR_RST_ZERO;
      chr3_reg  <= `DCR_RST_ZERO;
    end
    else if (wr_pend_reg)
      unique case (waddr_reg)
        `DCR_A_CTRL:  ctrl_reg  <= hwdata;
        `DCR_A_WIND:  wind_reg  <= hwdata;
        `DCR_A_RATIO: ratio_reg <= hwdata;
        `DCR_A_HARM:  harm_reg  <= hwdata;
        `DCR_A_HARM4: harm4_reg <= hwdata;
        `DCR_A_TIME:  time_reg  <= hwdata;
        `DCR_A_CHR1:  chr1_reg  <= hwdata;
        `DCR_A_CHR2:  chr2_reg  <= hwdata;
        `DCR_A_CHR3:  chr3_reg  <= hwdata;
        default:      ;
      endcase
  end
  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = 1'b0;
  // ************************************************************
  // millisecond tick and transient window
  // ************************************************************
  logic [15:0] tick_cnt_reg;
  logic        ms_tick_reg;
  logic [15:0] trans_cnt_reg;
  logic        ener_prev_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_reg <= 16'h0000;
      ms_tick_reg  <= 1'b0;
    end
    else
    begin
      ms_tick_reg <= tick_cnt_reg == 16'(MS_CYCLES - 1);
      if (tick_cnt_reg == 16'(MS_CYCLES - 1))
        tick_cnt_reg <= 16'h0000;
      else
        tick_cnt_reg <= 16'(tick_cnt_reg + 16'h1);
    end
  end
  // the window restarts on each energization edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ener_prev_reg <= 1'b0;
      trans_cnt_reg <= 16'h0000;
      trans_act_reg <= 1'b0;
    end
    else
    begin
      ener_prev_reg <= meas.energized;
      if (meas.energized && !ener_prev_reg)
        trans_cnt_reg <= time_reg[`DCR_F_LO];
      else if (ms_tick_reg && trans_cnt_reg != 16'h0000)
        trans_cnt_reg <= 16'(trans_cnt_reg - 16'h1);
      trans_act_reg <= trans_cnt_reg != 16'h0000;
    end
  end
  // ************************************************************
  // compensation
  // ************************************************************
  dcr_ph3_t w1_comp, w2_comp;
  logic     w1_gnd, w2_gnd;
  function automatic logic grounded(input logic [2:0] s);
    grounded = s == DCR_YN || s == DCR_ZN;
  endfunction
  assign w1_gnd = grounded(wind_reg[`DCR_F_W1S]);
  assign w2_gnd = grounded(wind_reg[`DCR_F_W2S]);
  dcr_comp u_comp_w1
  (
    .phin    (meas.w1),
    .vratio  (`DCR_RATIO_ONE),
    .ctratio (`DCR_RATIO_ONE),
    .rot     (4'h0),
    .acb     (1'b0),
    .rm_zero (w1_gnd),
    .phout   (w1_comp)
  );
  dcr_comp u_comp_w2
  (
    .phin    (meas.w2),
    .vratio  (ratio_reg[`DCR_F_LO]),
    .ctratio (ratio_reg[`DCR_F_HI]),
    .rot     (wind_reg[`DCR_F_VG]),
    .acb     (ctrl_reg[`DCR_B_ACB]),
    .rm_zero (w2_gnd),
    .phout   (w2_comp)
  );
  // ************************************************************
  // restraint triggers and trip comparison per phase
  // ************************************************************
  logic [2:0]  harm_trig, sat_act, raw_trig, restr, trip_now;
  logic [15:0] offs;
  assign offs = harm4_reg[`DCR_F_HI];
  // static characteristic; k1, k2 in q8.8 per base current
  function automatic logic [16:0] char_thr(input logic [15:0] is_m);
    logic [31:0] m;
    logic [16:0] a;
    m = 32'h0;
    a = 17'h0;
    if (is_m < chr2_reg[`DCR_F_HI])
    begin
      m = chr3_reg[`DCR_F_LO] * is_m;
      a = 17'(chr1_reg[`DCR_F_HI]) + 17'(m[23:8]);
      char_thr = (a > 17'(chr1_reg[`DCR_F_LO])) ? a
                 : 17'(chr1_reg[`DCR_F_LO]);
    end
    else
    begin
      m = chr3_reg[`DCR_F_HI] * 16'(is_m - chr2_reg[`DCR_F_HI]);
      char_thr = 17'(chr2_reg[`DCR_F_LO]) + 17'(m[23:8]);
    end
  endfunction
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_ph
      logic        h2_hit, h4_hit, h5_hit;
      logic [17:0] thr_tot;
      assign h2_hit = ctrl_reg[`DCR_B_H2EN] && meas.h2_pct[p] >
        (trans_act_reg ? harm_reg[`DCR_F_H2T]
                       : harm_reg[`DCR_F_H2S]);
      assign h4_hit = ctrl_reg[`DCR_B_H4EN]
        && meas.h4_pct[p] > harm4_reg[`DCR_F_H4];
      assign h5_hit = ctrl_reg[`DCR_B_H5EN] && meas.h5_pct[p] >
        (trans_act_reg ? harm_reg[`DCR_F_H5T]
                       : harm_reg[`DCR_F_H5S]);
      assign harm_trig[p] = h2_hit || h4_hit || h5_hit;
      dcr_satdet #(.BLOCK_MS(BLOCK_MS)) u_sat
      (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .enable    (ctrl_reg[`DCR_B_SATEN]),
        .zc        (meas_valid && meas.zc[p]),
        .ext_fault (meas.is_rise[p] && !meas.id_rise[p]),
        .int_fault (meas.is_rise[p] && meas.id_rise[p]),
        .ms_tick   (ms_tick_reg),
        .max_ms    (time_reg[`DCR_F_HI]),
        .active    (sat_act[p]),
        .locked    (sat_lock[p])
      );
      // process form so that a curve register write alone re-evaluates
      always_comb
        thr_tot = 18'(char_thr(meas.is_mag[p]))
          + 18'(restr[p] ? offs : 16'h0000);
      assign trip_now[p] = 18'(meas.id_mag[p]) >= thr_tot;
    end
  endgenerate
  assign raw_trig = harm_trig | sat_act;
  assign restr = ctrl_reg[`DCR_B_XBLK] ? {3{|raw_trig}}
                                       : raw_trig;
  // ************************************************************
  // result register, refreshed on every phasor update
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_reg       <= '0;
      res_valid_reg <= 1'b0;
    end
    else
    begin
      res_valid_reg <= meas_valid;
      if (meas_valid)
      begin
        res_reg.w1        <= w1_comp;
        res_reg.w2        <= w2_comp;
        res_reg.offset[0] <= restr[0] ? offs : 16'h0000;
        res_reg.offset[1] <= restr[1] ? offs : 16'h0000;
        res_reg.offset[2] <= restr[2] ? offs : 16'h0000;
        res_reg.restraint <= restr;
        res_reg.trip      <= trip_now;
      end
    end
  end
  assign res       = res_reg;
  assign res_valid = res_valid_reg;
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_w1_reference: assert property (meas_valid && !w1_gnd
    |=> res.w1 == $past(meas.w1)) else $error("w1 altered");
  a_vg_unity: assert property (meas_valid && wind_reg[`DCR_F_VG] == 4'h0
    && ratio_reg == `DCR_RST_RATIO && !w2_gnd
    |=> res.w2 == $past(meas.w2)) else $error("w2 unity altered");
  a_offset_use: assert property (res_valid |-> res.offset[0] ==
    (res.restraint[0] ? $past(offs) : 16'h0000)) else $error("bad offset");
  a_cross_block: assert property (meas_valid && ctrl_reg[`DCR_B_XBLK]
    |=> &res.restraint || ~|res.restraint) else $error("cross block");
  a_h4_trigger: assert property (meas_valid && ctrl_reg[`DCR_B_H4EN]
    && meas.h4_pct[0] > harm4_reg[`DCR_F_H4]
    |=> res.restraint[0]) else $error("h4 missed");
  a_trans_start: assert property ($rose(meas.energized)
    && time_reg[`DCR_F_LO] != 16'h0000 |=> ##1 trans_act_reg)
    else $error("transient window not opened");
  a_trip_low: assert property (meas_valid
    && meas.id_mag[0] < chr1_reg[`DCR_F_LO] |=> !res.trip[0])
    else $error("trip below minimum");
  c_trip: cover property (res_valid && |res.trip);
  c_restr_trans: cover property (trans_act_reg && res_valid
    && res.restraint[0]);
  c_xblk: cover property (res_valid && &res.restraint);
endmodule // dcr_top

/* File: testbench/dcr_meas_model.sv */
// measurement channel model: one phasor update per call
// assumes the bench calls send only after reset release
`timescale 1ns/1ns
module dcr_meas_model
(
  input  wire logic   hclk,       // clock
  output logic        meas_valid, // update strobe
  output dcr_pkg::dcr_meas_t meas // measured values
);
  import dcr_pkg::*;
  initial
  begin
    meas_valid = 1'b0;
    meas       = '0;
  end
  // strobe lasts one cycle; values stand until the next update
  task automatic send(input dcr_meas_t m);
    @(posedge hclk);
    meas_valid <= 1'b1;
    meas       <= m;
    @(posedge hclk);
    meas_valid <= 1'b0;
  endtask
endmodule // dcr_meas_model

/* File: testbench/tb_diff_current_compensation_restraint.sv */
// bench: register bus, compensation, harmonic and saturation restraint
// assumes 4-cycle ms ticks and a three-tick lockout
`timescale 1ns/1ns
`include "dcr_defines.svh"
module tb_diff_current_compensation_restraint;
  import dcr_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b000;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic        hreadyout, hresp, meas_valid, res_valid;
  dcr_meas_t   meas, m;
  dcr_result_t res;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  always #25 hclk = ~hclk;
  dcr_meas_model pm (.hclk(hclk), .meas_valid(meas_valid), .meas(meas));
  dcr_top #(.MS_CYCLES(4), .BLOCK_MS(3)) uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .meas_valid(meas_valid), .meas(meas),
    .res_valid(res_valid), .res(res)
  );
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= `DCR_HSIZE_WORD;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp(hresp, 1'b0, "okay response");
  endtask
  task automatic upd(input logic [2:0] rs, input logic [15:0] off);
    pm.send(m);
    #1;
    cmp(res_valid, 1, "result strobe");
    cmp(res.restraint, rs, "restraint");
    cmp(res.offset[0], off, "offset");
  endtask
  task automatic sat_start;
    m.zc[0] = 1'b1;
    m.id_rise[0] = 1'b0;
    pm.send(m);
    m.zc[0] = 1'b0;
  endtask
  task automatic t_regs;
    bus(0, `DCR_A_RATIO, 0);
    cmp(rd, `DCR_RST_RATIO, "ratio reset");
    bus(0, 8'h80, 0);
    cmp(rd, 0, "unmapped read");
    bus(1, `DCR_A_HARM, 32'h2010_3020);
    bus(0, `DCR_A_HARM, 0);
    cmp(rd, 32'h2010_3020, "levels readback");
  endtask
  task automatic t_comp;
    m = '0;
    m.w1[0] = {16'sd300, -16'sd200};
    m.w2[0] = {16'sd120, 16'sd80};
    bus(1, `DCR_A_CTRL, 0);
    upd(3'b000, 16'h0);
    cmp(res.w1[0], m.w1[0], "w1 reference");
    cmp(res.w2[0], m.w2[0], "w2 unit ratio");
    bus(1, `DCR_A_WIND, 32'h6);
    upd(3'b000, 16'h0);
    cmp(res.w2[0], {-16'sd120, -16'sd80}, "w2 half turn");
    m.w2[0] = {-16'sd120, 16'sd80};
    bus(1, `DCR_A_RATIO, 32'h1800_2000);
    upd(3'b000, 16'h0);
    cmp(res.w2[0], {16'sd360, -16'sd240}, "w2 scaled");
    bus(1, `DCR_A_RATIO, `DCR_RST_RATIO);
    bus(1, `DCR_A_WIND, 32'h3);
    bus(1, `DCR_A_CTRL, 32'h20);
    m.w2[0] = {16'sd120, 16'sd80};
    upd(3'b000, 16'h0);
    cmp(res.w2[0], {16'sd80, -16'sd120}, "w2 acb quarter");
    bus(1, `DCR_A_WIND, 32'h300);
    m.w2[0] = {-16'sd120, -16'sd60};
    upd(3'b000, 16'h0);
    cmp(res.w2[0], {-16'sd80, -16'sd40}, "w2 zero seq a");
    cmp(res.w2[1], {16'sd40, 16'sd20}, "w2 zero seq b");
  endtask
  task automatic t_harm;
    bus(1, `DCR_A_HARM4, 32'h0280_0040);
    bus(1, `DCR_A_CTRL, 32'h7);
    m = '0;
    m.h2_pct[0] = 8'h31;
    upd(3'b001, 16'h0280);
    m.h2_pct[0] = 8'h30;
    m.h4_pct[1] = 8'h41;
    upd(3'b010, 16'h0);
    m.h4_pct[1] = 8'h40;
    m.h5_pct[2] = 8'h21;
    upd(3'b100, 16'h0);
    bus(1, `DCR_A_CTRL, 32'h10);
    upd(3'b000, 16'h0);
    bus(1, `DCR_A_CTRL, 32'h14);
    upd(3'b111, 16'h0280);
  endtask
  task automatic t_trans;
    bus(1, `DCR_A_CTRL, 32'h1);
    bus(1, `DCR_A_TIME, 32'h2);
    m = '0;
    m.energized = 1'b1;
    pm.send(m);
    m.h2_pct[0] = 8'h21;
    upd(3'b001, 16'h0280);
    bus(0, `DCR_A_STAT, 0);
    cmp(rd[6], 1'b1, "window flag");
    repeat (12) @(posedge hclk);
    upd(3'b000, 16'h0);
  endtask
  task automatic t_trip;
    bus(1, `DCR_A_CHR1, 32'h0100_0080);
    bus(1, `DCR_A_CHR2, 32'h0400_0300);
    bus(1, `DCR_A_CHR3, 32'h0100_0080);
    m = '0;
    m.is_mag[0] = 16'h0200;
    m.id_mag[0] = 16'h01FF;
    upd(3'b000, 16'h0);
    cmp(res.trip, 3'b000, "below curve");
    m.id_mag[0] = 16'h0200;
    upd(3'b000, 16'h0);
    cmp(res.trip, 3'b001, "on curve");
    m.h2_pct[0] = 8'h31;
    upd(3'b001, 16'h0280);
    cmp(res.trip, 3'b000, "offset raises curve");
  endtask
  task automatic t_sat;
    bus(1, `DCR_A_TIME, 32'h0010_0000);
    bus(1, `DCR_A_CTRL, 32'h8);
    m = '0;
    m.zc[0] = 1'b1;
    m.is_rise[0] = 1'b1;
    m.id_rise[0] = 1'b1;
    upd(3'b000, 16'h0);
    m.zc[0] = 1'b0;
    upd(3'b000, 16'h0);
    sat_start;
    upd(3'b001, 16'h0280);
    m.zc[0] = 1'b1;
    m.id_rise[0] = 1'b1;
    repeat (2) pm.send(m);
    m.zc[0] = 1'b0;
    upd(3'b000, 16'h0);
    sat_start;
    upd(3'b000, 16'h0);
    repeat (20) @(posedge hclk);
    sat_start;
    upd(3'b001, 16'h0280);
    repeat (80) @(posedge hclk);
    upd(3'b000, 16'h0);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_comp;
    t_harm;
    t_trans;
    t_trip;
    t_sat;
    close_out;
  end
endmodule // tb_diff_current_compensation_restraint
